/* File: logic/delay_if.sv */
`timescale 1ns/100ps
interface delay_if;
    logic pin_level;
    logic [3:0] on_code;
    logic [3:0] off_code;
    logic on_long;
    logic off_long;
    logic delayed_level;

    modport timer (
        input pin_level,
        input on_code,
        input off_code,
        input on_long,
        input off_long,
        output delayed_level
    );

    modport owner (
        output pin_level,
        output on_code,
        output off_code,
        output on_long,
        output off_long,
        input delayed_level
    );
endinterface : delay_if

/* File: logic/edge_delay_timer.sv */
`timescale 1ns/100ps
`include "seq_params.svh"
module edge_delay_timer #(
    parameter logic [17:0] STEP_CYCLES = 18'(`STEP_SHORT_CYCLES)
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    // timing channel
    delay_if.timer tif
);
    import seq_pkg::*;

    timer_t q;
    timer_t d;
    logic rise;
    logic fall;
    logic [17:0] lim;

    assign tif.delayed_level = q.level;

    always_comb
    begin
        d = q;
        rise = tif.pin_level & ~q.pin_prev;
        fall = ~tif.pin_level & q.pin_prev;
        lim = q.long_step ? 18'(STEP_CYCLES << 1) : STEP_CYCLES;
        d.pin_prev = tif.pin_level;
        if (rise)
        begin
            // codes latched at the edge only; reversal cancels
            if (q.level || tif.on_code == 4'h0)
            begin
                d.level = 1'b1;
                d.st = T_IDLE;
            end
            else
            begin
                d.st = T_WAIT_ON;
                d.steps = tif.on_code;
                d.long_step = tif.on_long;
                d.presc = 18'h00000;
            end
        end
        else if (fall)
        begin
            if (!q.level || tif.off_code == 4'h0)
            begin
                d.level = 1'b0;
                d.st = T_IDLE;
            end
            else
            begin
                d.st = T_WAIT_OFF;
                d.steps = tif.off_code;
                d.long_step = tif.off_long;
                d.presc = 18'h00000;
            end
        end
        else if (q.st != T_IDLE)
        begin
            // one step is 0.5 ms, or 1 ms in the long range
            if (q.presc == 18'(lim - 18'h00001))
            begin
                d.presc = 18'h00000;
                if (q.steps == 4'h1)
                begin
                    d.level = (q.st == T_WAIT_ON);
                    d.st = T_IDLE;
                end
                else
                begin
                    d.steps = 4'(q.steps - 4'h1);
                end
            end
            else
            begin
                d.presc = 18'(q.presc + 18'h00001);
            end
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            q <= '{st: T_IDLE, level: 1'b0, pin_prev: 1'b0,
                   long_step: 1'b0, steps: 4'h0, presc: 18'h00000};
        end
        else if (ce_in)
        begin
            q <= d;
        end
    end
endmodule : edge_delay_timer

/* File: logic/regulator_sequencer.sv */
`timescale 1ns/100ps
`include "seq_params.svh"
module regulator_sequencer #(
    parameter logic [17:0] STEP_CYCLES = 18'(`STEP_SHORT_CYCLES)
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    // register access
    input wire seq_pkg::reg_addr_t reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // enable pin
    input wire logic enable_pin_in,
    // channel 0
    output logic ch0_run_out,
    output logic ch0_discharge_out,
    output logic ch0_force_fixed_modulation_out,
    output logic [11:0] ch0_millivolts_out,
    output logic ch0_voltage_reserved_out,
    // channel 1
    output logic ch1_run_out,
    output logic ch1_discharge_out,
    output logic ch1_force_fixed_modulation_out,
    output logic [11:0] ch1_millivolts_out,
    output logic ch1_voltage_reserved_out,
    output logic [11:0] ch1_current_limit_ma_out,
    output logic ch1_current_limit_reserved_out,
    output logic [10:0] ch1_ramp_rate_out,
    output logic ch1_ramp_rate_reserved_out,
    // general purpose output
    output logic aux_output_out
);
    import seq_pkg::*;

    main_t q;
    main_t d;

    delay_if ch0_tif ();
    delay_if ch1_tif ();
    delay_if aux_tif ();

    // two-segment voltage decode, shared by both channels
    function automatic logic [11:0] code_to_mv(input logic [7:0] code);
        logic [11:0] c;
        c = {4'h0, code};
        if (c < `VCODE_LOW_FIRST)
        begin
            code_to_mv = 12'h000;
        end
        else if (c <= `VCODE_LOW_LAST)
        begin
            code_to_mv = 12'(`MV_LOW_BASE
                + (c - `VCODE_LOW_FIRST) * `MV_LOW_STEP);
        end
        else
        begin
            code_to_mv = 12'(`MV_HIGH_BASE
                + (c - `VCODE_HIGH_FIRST) * `MV_HIGH_STEP);
        end
    endfunction : code_to_mv

    function automatic logic code_reserved(input logic [7:0] code);
        code_reserved = {4'h0, code} < `VCODE_LOW_FIRST;
    endfunction : code_reserved

    // regulator runs from its bit, optionally gated by the delayed pin
    function automatic logic run_of(
        input logic [7:0] ctrl,
        input logic pin_view
    );
        run_of = ctrl[`CTRL_ON_BIT]
            & (~ctrl[`CTRL_PIN_BIT] | pin_view);
    endfunction : run_of

    function automatic logic [11:0] lim_to_ma(input logic [2:0] code);
        if (code > `LIM_LAST_CODE)
        begin
            lim_to_ma = 12'h000;
        end
        else
        begin
            lim_to_ma = 12'(`LIM_BASE_MA
                + {9'h000, code} * `LIM_STEP_MA);
        end
    endfunction : lim_to_ma

    function automatic logic [10:0] ramp_rate(input logic [2:0] code);
        case (code)
            3'h2: ramp_rate = `RAMP_C2;
            3'h3: ramp_rate = `RAMP_C3;
            3'h4: ramp_rate = `RAMP_C4;
            3'h5: ramp_rate = `RAMP_C5;
            3'h6: ramp_rate = `RAMP_C6;
            3'h7: ramp_rate = `RAMP_C7;
            default: ramp_rate = 11'h000;
        endcase
    endfunction : ramp_rate

    // delay timers, one per output
    assign ch0_tif.pin_level = enable_pin_in;
    assign ch0_tif.on_code = q.ch0_delay[`DELAY_ON_HI:`DELAY_ON_LO];
    assign ch0_tif.off_code = q.ch0_delay[`DELAY_OFF_HI:`DELAY_OFF_LO];
    assign ch0_tif.on_long = q.config_r[`CFG_ON_LONG_BIT];
    assign ch0_tif.off_long = q.config_r[`CFG_OFF_LONG_BIT];

    assign ch1_tif.pin_level = enable_pin_in;
    assign ch1_tif.on_code = q.ch1_delay[`DELAY_ON_HI:`DELAY_ON_LO];
    assign ch1_tif.off_code = q.ch1_delay[`DELAY_OFF_HI:`DELAY_OFF_LO];
    assign ch1_tif.on_long = q.config_r[`CFG_ON_LONG_BIT];
    assign ch1_tif.off_long = q.config_r[`CFG_OFF_LONG_BIT];

    assign aux_tif.pin_level = enable_pin_in;
    assign aux_tif.on_code = q.aux_delay[`DELAY_ON_HI:`DELAY_ON_LO];
    assign aux_tif.off_code = q.aux_delay[`DELAY_OFF_HI:`DELAY_OFF_LO];
    assign aux_tif.on_long = q.config_r[`CFG_ON_LONG_BIT];
    assign aux_tif.off_long = q.config_r[`CFG_OFF_LONG_BIT];

    edge_delay_timer #(
        .STEP_CYCLES(STEP_CYCLES)
    ) ch0_timer (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .ce_in(ce_in),
        .tif(ch0_tif)
    );

    edge_delay_timer #(
        .STEP_CYCLES(STEP_CYCLES)
    ) ch1_timer (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .ce_in(ce_in),
        .tif(ch1_tif)
    );

    edge_delay_timer #(
        .STEP_CYCLES(STEP_CYCLES)
    ) aux_timer (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .ce_in(ce_in),
        .tif(aux_tif)
    );

    always_comb
    begin
        d = q;
        // register writes
        if (reg_wr_in)
        begin
            case (reg_addr_in)
                `ADDR_CH0_CTRL: d.ch0_ctrl = reg_wdata_in;
                `ADDR_CH1_CTRL_A: d.ch1_ctrl_a = reg_wdata_in;
                `ADDR_CH1_CTRL_B: d.ch1_ctrl_b = reg_wdata_in;
                `ADDR_CH0_VOUT: d.ch0_vout = reg_wdata_in;
                `ADDR_CH1_VOUT: d.ch1_vout = reg_wdata_in;
                `ADDR_CH0_DELAY: d.ch0_delay = reg_wdata_in;
                `ADDR_CH1_DELAY: d.ch1_delay = reg_wdata_in;
                `ADDR_AUX_DELAY: d.aux_delay = reg_wdata_in;
                `ADDR_CONFIG: d.config_r = reg_wdata_in;
                default: d.rdata = q.rdata;
            endcase
        end
        // register reads, unmapped reads return zero
        if (reg_rd_in)
        begin
            case (reg_addr_in)
                `ADDR_CH0_CTRL: d.rdata = q.ch0_ctrl;
                `ADDR_CH1_CTRL_A: d.rdata = q.ch1_ctrl_a;
                `ADDR_CH1_CTRL_B: d.rdata = q.ch1_ctrl_b;
                `ADDR_CH0_VOUT: d.rdata = q.ch0_vout;
                `ADDR_CH1_VOUT: d.rdata = q.ch1_vout;
                `ADDR_CH0_DELAY: d.rdata = q.ch0_delay;
                `ADDR_CH1_DELAY: d.rdata = q.ch1_delay;
                `ADDR_AUX_DELAY: d.rdata = q.aux_delay;
                `ADDR_CONFIG: d.rdata = q.config_r;
                `ADDR_STATUS:
                begin
                    d.rdata = 8'h00;
                    d.rdata[`STAT_CH1_BIT] = q.ch1_run;
                    d.rdata[`STAT_CH0_BIT] = q.ch0_run;
                end
                default: d.rdata = 8'h00;
            endcase
        end
        // enable gating
        d.ch0_run = run_of(q.ch0_ctrl, ch0_tif.delayed_level);
        d.ch1_run = run_of(q.ch1_ctrl_a, ch1_tif.delayed_level);
        d.ch0_dis = ~q.ch0_run & q.ch0_ctrl[`CTRL_DIS_BIT];
        d.ch1_dis = ~q.ch1_run & q.ch1_ctrl_a[`CTRL_DIS_BIT];
        d.ch0_fpwm = q.ch0_ctrl[`CTRL_FPWM_BIT];
        d.ch1_fpwm = q.ch1_ctrl_a[`CTRL_FPWM_BIT];
        d.aux = aux_tif.delayed_level;
        // voltage decode
        d.ch0_mv = code_to_mv(q.ch0_vout);
        d.ch1_mv = code_to_mv(q.ch1_vout);
        d.ch0_v_bad = code_reserved(q.ch0_vout);
        d.ch1_v_bad = code_reserved(q.ch1_vout);
        // current limit and ramp decode, live while running
        d.ch1_lim_ma = lim_to_ma(
            q.ch1_ctrl_b[`CTRLB_LIM_HI:`CTRLB_LIM_LO]);
        d.ch1_lim_bad =
            q.ch1_ctrl_b[`CTRLB_LIM_HI:`CTRLB_LIM_LO] > `LIM_LAST_CODE;
        d.ch1_ramp = ramp_rate(
            q.ch1_ctrl_b[`CTRLB_RAMP_HI:`CTRLB_RAMP_LO]);
        d.ch1_ramp_bad =
            q.ch1_ctrl_b[`CTRLB_RAMP_HI:`CTRLB_RAMP_LO] < `RAMP_FIRST_CODE;
    end

    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            q <= '0;
            q.ch0_ctrl <= `RST_CTRL;
            q.ch1_ctrl_a <= `RST_CTRL;
            q.ch1_ctrl_b <= `RST_CTRLB;
            q.ch0_vout <= `RST_VOUT;
            q.ch1_vout <= `RST_VOUT;
            q.ch0_delay <= `RST_DELAY;
            q.ch1_delay <= `RST_DELAY;
            q.aux_delay <= `RST_DELAY;
            q.config_r <= `RST_CONFIG;
            q.rdata <= `RST_RDATA;
            q.ch0_dis <= 1'b1;
            q.ch1_dis <= 1'b1;
            q.ch0_mv <= `MV_LOW_BASE;
            q.ch1_mv <= `MV_LOW_BASE;
            q.ch1_lim_ma <= `LIM_BASE_MA;
            q.ch1_ramp <= `RAMP_C2;
        end
        else if (ce_in)
        begin
            q <= d;
        end
    end

    // outputs
    assign reg_rdata_out = q.rdata;
    assign ch0_run_out = q.ch0_run;
    assign ch0_discharge_out = q.ch0_dis;
    assign ch0_force_fixed_modulation_out = q.ch0_fpwm;
    assign ch0_millivolts_out = q.ch0_mv;
    assign ch0_voltage_reserved_out = q.ch0_v_bad;
    assign ch1_run_out = q.ch1_run;
    assign ch1_discharge_out = q.ch1_dis;
    assign ch1_force_fixed_modulation_out = q.ch1_fpwm;
    assign ch1_millivolts_out = q.ch1_mv;
    assign ch1_voltage_reserved_out = q.ch1_v_bad;
    assign ch1_current_limit_ma_out = q.ch1_lim_ma;
    assign ch1_current_limit_reserved_out = q.ch1_lim_bad;
    assign ch1_ramp_rate_out = q.ch1_ramp;
    assign ch1_ramp_rate_reserved_out = q.ch1_ramp_bad;
    assign aux_output_out = q.aux;

endmodule : regulator_sequencer

/* File: logic/seq_params.svh */
// Operation
// - ctrl bit 3 picks auto or forced modulation
// - disabled channel discharges when discharge bit set
// - ch1 pin gating: bit alone, or bit and pin
// - ch1 enable bit 0 turns regulator on
// - limit codes 0-5 give 1.5-4.0 A, 6-7 reserved
// - limit code applies live, no restart
// - ramp codes 2-7 set rate, 0-1 reserved
// - voltage codes 0x4C-0x9D: 1-1.405 V, 5 mV
// - voltage codes 0x9E-0xFF: 1.42-3.36 V, 20 mV
// - ch1 voltage code decodes like ch0
// - ch0 waits startup code after pin rise
// - startup range bit makes 1 ms steps
// - ch0 waits shutdown code after pin fall
// - shutdown range bit makes 1 ms steps
// - delay register: off code 7:4, on 3:0
// - aux output rises after its startup delay
// - aux output falls after its shutdown delay
// - ch0 pin gating like ch1
// - range bits choose 0.5 or 1 ms steps
`ifndef SEQ_PARAMS_SVH
`define SEQ_PARAMS_SVH

// register offsets
`define ADDR_CH0_CTRL 8'h02
`define ADDR_CH1_CTRL_A 8'h04
`define ADDR_CH1_CTRL_B 8'h05
`define ADDR_CH0_VOUT 8'h06
`define ADDR_CH1_VOUT 8'h07
`define ADDR_CH0_DELAY 8'h0C
`define ADDR_CH1_DELAY 8'h0D
`define ADDR_AUX_DELAY 8'h10
`define ADDR_CONFIG 8'h13
`define ADDR_STATUS 8'h1E

// control, delay, config and status register fields
`define CTRL_FPWM_BIT 3
`define CTRL_DIS_BIT 2
`define CTRL_PIN_BIT 1
`define CTRL_ON_BIT 0
`define CTRLB_LIM_HI 5
`define CTRLB_LIM_LO 3
`define CTRLB_RAMP_HI 2
`define CTRLB_RAMP_LO 0
`define DELAY_OFF_HI 7
`define DELAY_OFF_LO 4
`define DELAY_ON_HI 3
`define DELAY_ON_LO 0
`define CFG_ON_LONG_BIT 6
`define CFG_OFF_LONG_BIT 5
`define STAT_CH1_BIT 7
`define STAT_CH0_BIT 3

// reset values
`define RST_CTRL 8'h04
`define RST_CTRLB 8'h02
`define RST_VOUT 8'h4C
`define RST_DELAY 8'h00
`define RST_CONFIG 8'h00
`define RST_RDATA 8'h00

// voltage decode
`define VCODE_LOW_FIRST 12'h04C
`define VCODE_LOW_LAST 12'h09D
`define VCODE_HIGH_FIRST 12'h09E
`define MV_LOW_BASE 12'h3E8
`define MV_LOW_STEP 12'h005
`define MV_HIGH_BASE 12'h58C
`define MV_HIGH_STEP 12'h014

// current limit decode
`define LIM_LAST_CODE 3'h5
`define LIM_BASE_MA 12'h5DC
`define LIM_STEP_MA 12'h1F4

// ramp decode, hundredths of mV per us
`define RAMP_FIRST_CODE 3'h2
`define RAMP_C2 11'h3E8
`define RAMP_C3 11'h2EE
`define RAMP_C4 11'h17C
`define RAMP_C5 11'h0BE
`define RAMP_C6 11'h05E
`define RAMP_C7 11'h02F

// timing
`define CLK_MHZ 125
`define STEP_SHORT_US 500
`define STEP_SHORT_CYCLES (`STEP_SHORT_US * `CLK_MHZ)
`define PRESC_W 18

`endif

/* File: logic/seq_pkg.sv */
package seq_pkg;

    typedef logic [7:0] reg_addr_t;

    typedef enum logic [2:0] {
        T_IDLE = 3'b001,
        T_WAIT_ON = 3'b010,
        T_WAIT_OFF = 3'b100
    } timer_state_t;

    typedef struct packed {
        timer_state_t st;
        logic level;
        logic pin_prev;
        logic long_step;
        logic [3:0] steps;
        logic [17:0] presc;
    } timer_t;

    typedef struct packed {
        logic [7:0] ch0_ctrl;
        logic [7:0] ch1_ctrl_a;
        logic [7:0] ch1_ctrl_b;
        logic [7:0] ch0_vout;
        logic [7:0] ch1_vout;
        logic [7:0] ch0_delay;
        logic [7:0] ch1_delay;
        logic [7:0] aux_delay;
        logic [7:0] config_r;
        logic [7:0] rdata;
        logic ch0_run;
        logic ch1_run;
        logic ch0_dis;
        logic ch1_dis;
        logic ch0_fpwm;
        logic ch1_fpwm;
        logic aux;
        logic [11:0] ch0_mv;
        logic [11:0] ch1_mv;
        logic ch0_v_bad;
        logic ch1_v_bad;
        logic [11:0] ch1_lim_ma;
        logic ch1_lim_bad;
        logic [10:0] ch1_ramp;
        logic ch1_ramp_bad;
    } main_t;

endpackage : seq_pkg

/* File: testbench/host_reg_model.sv */
`timescale 1ns/100ps
module host_reg_model (
    // clock
    input wire logic clk_in,
    // register port
    output seq_pkg::reg_addr_t reg_addr_out,
    output logic [7:0] reg_wdata_out,
    output logic reg_wr_out,
    output logic reg_rd_out,
    input wire logic [7:0] reg_rdata_in
);
    import seq_pkg::*;
    initial
    begin
        reg_addr_out = 8'h00;
        reg_wdata_out = 8'h00;
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
    end
    task automatic write_reg(input reg_addr_t a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        // reserved voltage codes never sent
        if ((a == 8'h06 || a == 8'h07) && v < 8'h4C) v = 8'h4C;
        @(posedge clk_in);
        #1;
        reg_addr_out = a;
        reg_wdata_out = v;
        reg_wr_out = 1'b1;
        @(posedge clk_in);
        #1;
        reg_wr_out = 1'b0;
        reg_wdata_out = ~v;
    endtask : write_reg
    task automatic read_reg(input reg_addr_t a, output logic [7:0] d);
        @(posedge clk_in);
        #1;
        reg_addr_out = a;
        reg_rd_out = 1'b1;
        @(posedge clk_in);
        #1;
        reg_rd_out = 1'b0;
        @(posedge clk_in);
        #1;
        d = reg_rdata_in;
    endtask : read_reg
endmodule : host_reg_model

/* File: testbench/seq_checker_assertions.sv */
`timescale 1ns/100ps
module seq_checker (
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // register port and pin
    input wire logic ce_in,
    input wire seq_pkg::reg_addr_t reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic enable_pin_in,
    // observed outputs
    input wire logic ch0_run_out,
    input wire logic ch0_discharge_out,
    input wire logic ch1_run_out,
    input wire logic ch1_discharge_out,
    input wire logic [11:0] ch0_millivolts_out,
    input wire logic ch0_voltage_reserved_out,
    input wire logic [11:0] ch1_millivolts_out,
    input wire logic ch1_voltage_reserved_out,
    input wire logic [11:0] ch1_current_limit_ma_out,
    input wire logic ch1_current_limit_reserved_out,
    input wire logic [10:0] ch1_ramp_rate_out,
    input wire logic aux_output_out
);
    import seq_pkg::*;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    logic wr_lim;
    logic [2:0] lim_code_q;
    assign wr_lim = ce_in && reg_wr_in && reg_addr_in == 8'h05;
    // last limit code written by the host
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            lim_code_q <= 3'h0;
        else if (wr_lim)
            lim_code_q <= reg_wdata_in[5:3];
    end
    ch0_dis_off_a: assert property (
        ch0_run_out |=> !ch0_discharge_out)
        else $error("ch0 discharge while running");
    ch1_dis_off_a: assert property (
        ch1_run_out |=> !ch1_discharge_out)
        else $error("ch1 discharge while running");
    ch0_volt_range_a: assert property (
        ch0_voltage_reserved_out ? ch0_millivolts_out == 12'h000 :
        (ch0_millivolts_out >= 12'h3E8 && ch0_millivolts_out <= 12'hD20))
        else $error("ch0 millivolts out of range");
    ch1_volt_range_a: assert property (
        ch1_voltage_reserved_out ? ch1_millivolts_out == 12'h000 :
        (ch1_millivolts_out >= 12'h3E8 && ch1_millivolts_out <= 12'hD20))
        else $error("ch1 millivolts out of range");
    lim_decode_a: assert property (
        ch1_current_limit_reserved_out ? ch1_current_limit_ma_out == 12'h000
        : ch1_current_limit_ma_out inside {12'h5DC, 12'h7D0, 12'h9C4,
        12'hBB8, 12'hDAC, 12'hFA0})
        else $error("current limit not a legal value");
    lim_live_a: assert property (
        wr_lim ##1 !wr_lim ##1 !wr_lim |=> ch1_current_limit_ma_out ==
        (lim_code_q > 3'h5 ? 12'h000 : 12'h5DC + 12'h1F4 * lim_code_q))
        else $error("written limit code not applied");
    ramp_decode_a: assert property (
        ch1_ramp_rate_out inside {11'h000, 11'h3E8, 11'h2EE, 11'h17C,
        11'h0BE, 11'h05E, 11'h02F})
        else $error("ramp rate not a legal value");
    aux_rise_a: assert property (
        $rose(aux_output_out) |-> $past(enable_pin_in, 1))
        else $error("aux output rose without pin high");
    aux_fall_a: assert property (
        $fell(aux_output_out) |-> !$past(enable_pin_in, 1))
        else $error("aux output fell with pin high");
    cover property ($rose(ch0_run_out));
    cover property ($rose(aux_output_out));
    cover property (ch1_current_limit_reserved_out);
endmodule : seq_checker

bind regulator_sequencer seq_checker i_seq_checker (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in),
    .enable_pin_in(enable_pin_in),
    .ch0_run_out(ch0_run_out),
    .ch0_discharge_out(ch0_discharge_out),
    .ch1_run_out(ch1_run_out),
    .ch1_discharge_out(ch1_discharge_out),
    .ch0_millivolts_out(ch0_millivolts_out),
    .ch0_voltage_reserved_out(ch0_voltage_reserved_out),
    .ch1_millivolts_out(ch1_millivolts_out),
    .ch1_voltage_reserved_out(ch1_voltage_reserved_out),
    .ch1_current_limit_ma_out(ch1_current_limit_ma_out),
    .ch1_current_limit_reserved_out(ch1_current_limit_reserved_out),
    .ch1_ramp_rate_out(ch1_ramp_rate_out),
    .aux_output_out(aux_output_out)
);

/* File: testbench/test_regulator_sequencer.sv */
`timescale 1ns/100ps
module test_regulator_sequencer;
    import seq_pkg::*;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic ce_in = 1'b1;
    logic pin = 1'b0;
    reg_addr_t addr;
    logic [7:0] wdata, rdata;
    logic wr, rd, ch0_run, ch0_dis, ch1_run, ch1_dis, ch1_fpwm, aux;
    logic [11:0] ch0_mv, ch1_mv, lim;
    logic [10:0] ramp;
    logic rrsv, ch0_fpwm;
    int failures = 0;
    int total_checks = 0;
    int cyc = 0;
    int edge_cyc = 0;
    always #4 clk_in = ~clk_in;
    always @(posedge clk_in) cyc <= cyc + 1;
    regulator_sequencer #(.STEP_CYCLES(18'h4)) i_regulator_sequencer (
        .clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce_in),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdata), .enable_pin_in(pin),
        .ch0_run_out(ch0_run), .ch0_discharge_out(ch0_dis),
        .ch0_force_fixed_modulation_out(ch0_fpwm), .ch0_millivolts_out(ch0_mv),
        .ch0_voltage_reserved_out(), .ch1_run_out(ch1_run),
        .ch1_discharge_out(ch1_dis),
        .ch1_force_fixed_modulation_out(ch1_fpwm),
        .ch1_millivolts_out(ch1_mv), .ch1_voltage_reserved_out(),
        .ch1_current_limit_ma_out(lim),
        .ch1_current_limit_reserved_out(), .ch1_ramp_rate_out(ramp),
        .ch1_ramp_rate_reserved_out(rrsv), .aux_output_out(aux));
    host_reg_model i_host_reg_model (.clk_in(clk_in), .reg_addr_out(addr),
        .reg_wdata_out(wdata), .reg_wr_out(wr), .reg_rd_out(rd),
        .reg_rdata_in(rdata));
    task automatic wreg(input reg_addr_t a, input logic [7:0] d);
        i_host_reg_model.write_reg(a, d);
    endtask : wreg
    task automatic check_val(input logic [11:0] got, want, input string s);
        total_checks++;
        if (got !== want)
        begin
            failures++;
            $display("BAD %0t %s got %0h want %0h", $time, s, got, want);
        end
    endtask : check_val
    task automatic check_time(input int got, want, input string s);
        total_checks++;
        if (got != want)
        begin
            failures++;
            $display("BAD %0t %s took %0d want %0d", $time, s, got, want);
        end
    endtask : check_time
    task automatic settle();
        repeat (3) @(posedge clk_in);
        #1;
    endtask : settle
    task automatic set_pin(input logic v);
        @(posedge clk_in);
        #1;
        pin = v;
        edge_cyc = cyc;
        @(posedge clk_in);
        #1;
    endtask : set_pin
    function automatic logic pick(input int s);
        return s == 0 ? ch0_run : (s == 1 ? ch1_run : aux);
    endfunction : pick
    // cycles from pin edge to output level
    task automatic wait_out(input int s, input logic v, input int want);
        int n;
        n = 0;
        while (pick(s) !== v && n < 200)
        begin
            @(posedge clk_in);
            #1;
            n++;
        end
        check_time(cyc - edge_cyc, want, "pin to output");
    endtask : wait_out
    task automatic test_reset();
        logic [7:0] ad [8] = '{8'h02, 8'h04, 8'h05, 8'h06, 8'h07, 8'h0C,
            8'h10, 8'h08};
        logic [7:0] rv [8] = '{8'h04, 8'h04, 8'h02, 8'h4C, 8'h4C, 8'h00,
            8'h00, 8'h00};
        logic [7:0] d;
        check_val(ch1_dis, 12'h001, "discharge at reset");
        check_val(ch0_mv, 12'h3E8, "ch0 mv at reset");
        for (int i = 0; i < 8; i++)
        begin
            i_host_reg_model.read_reg(ad[i], d);
            check_val(d, rv[i], "reset value");
        end
        $display("test_reset done");
    endtask : test_reset
    task automatic test_enable();
        wreg(8'h04, 8'h09);
        settle();
        check_val(ch1_run, 12'h001, "on bit");
        check_val(ch1_fpwm, 12'h001, "forced mode");
        check_val(ch1_dis, 12'h000, "no discharge running");
        wreg(8'h04, 8'h01);
        settle();
        check_val(ch1_fpwm, 12'h000, "auto mode");
        wreg(8'h04, 8'h00);
        settle();
        check_val(ch1_run, 12'h000, "off bit");
        check_val(ch1_dis, 12'h000, "discharge bit clear");
        wreg(8'h04, 8'h07);
        settle();
        check_val(ch1_run, 12'h000, "gated by low pin");
        check_val(ch1_dis, 12'h001, "discharge when off");
        set_pin(1'b1);
        wait_out(1, 1'b1, 2);
        set_pin(1'b0);
        wait_out(1, 1'b0, 2);
        $display("test_enable done");
    endtask : test_enable
    task automatic test_limit_ramp();
        logic [10:0] rt [8] = '{11'h000, 11'h000, 11'h3E8, 11'h2EE,
            11'h17C, 11'h0BE, 11'h05E, 11'h02F};
        wreg(8'h04, 8'h01);
        for (int c = 0; c < 8; c++)
        begin
            wreg(8'h05, {2'b00, 3'(c), 3'(c)});
            settle();
            check_val(lim, 12'(c > 5 ? 0 : 1500 + 500 * c), "limit");
            check_val(ramp, rt[c], "ramp");
            check_val(rrsv, 12'(c < 2), "ramp code");
            check_val(ch1_run, 12'h001, "no restart");
        end
        $display("test_limit_ramp done");
    endtask : test_limit_ramp
    task automatic test_voltage();
        logic [7:0] cd [5] = '{8'h4C, 8'h9D, 8'h9E, 8'hFF, 8'h60};
        logic [11:0] want;
        for (int i = 0; i < 5; i++)
        begin
            want = cd[i] <= 8'h9D ? 12'h3E8 + 12'h005 * (cd[i] - 8'h4C)
                : 12'h58C + 12'h014 * (cd[i] - 8'h9E);
            wreg(8'h06, cd[i]);
            wreg(8'h07, cd[i]);
            settle();
            check_val(ch0_mv, want, "ch0 voltage");
            check_val(ch1_mv, want, "ch1 voltage");
        end
        $display("test_voltage done");
    endtask : test_voltage
    task automatic test_delays();
        wreg(8'h02, 8'h0B);
        wreg(8'h04, 8'h03);
        wreg(8'h0C, 8'h32);
        wreg(8'h0D, 8'h10);
        wreg(8'h10, 8'h15);
        check_val(ch0_fpwm, 12'h001, "ch0 forced");
        set_pin(1'b1);
        wait_out(1, 1'b1, 2);
        wait_out(0, 1'b1, 10);
        wait_out(2, 1'b1, 22);
        set_pin(1'b0);
        wait_out(1, 1'b0, 6);
        wait_out(2, 1'b0, 6);
        wait_out(0, 1'b0, 14);
        wreg(8'h13, 8'h60);
        set_pin(1'b1);
        wreg(8'h0C, 8'h3F);
        wait_out(0, 1'b1, 18);
        set_pin(1'b0);
        wait_out(0, 1'b0, 26);
        $display("test_delays done");
    endtask : test_delays
    task automatic test_cancel();
        wreg(8'h13, 8'h00);
        wreg(8'h0C, 8'h05);
        set_pin(1'b1);
        repeat (6) @(posedge clk_in);
        set_pin(1'b0);
        repeat (30) @(posedge clk_in);
        #1;
        check_val(ch0_run, 12'h000, "ch0 start cancelled");
        check_val(aux, 12'h000, "aux start cancelled");
        $display("test_cancel done");
    endtask : test_cancel
    task automatic print_verdict();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict
    initial
    begin
        repeat (2) @(posedge clk_in);
        #1;
        nrst_in = 1'b1;
        test_reset();
        test_enable();
        test_limit_ramp();
        test_voltage();
        test_delays();
        test_cancel();
        print_verdict();
    end
    // tests take about 300 cycles
    initial
    begin
        #200000;
        failures++;
        $display("BAD %0t watchdog expired", $time);
        print_verdict();
    end
endmodule : test_regulator_sequencer
